// File: core/tls_pkg.sv
package tls_pkg;

  // ****************************************
  // Table geometry
  // ****************************************
  localparam int NT  = 32;
  localparam int NG  = 8;
  localparam int TPG = 4;
  localparam int AW  = 8;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DESIG = 8'h04;
  localparam logic [7:0] OFS_GSEL  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_LIFE  = 8'h10;
  localparam logic [7:0] OFS_TIDX  = 8'h14;
  localparam logic [7:0] OFS_TDATA = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_AVAIL = 0;
  localparam int CTRL_LATHE = 1;
  localparam int CTRL_CYC   = 2;
  localparam int STAT_TOOL  = 3;
  localparam int STAT_VALID = 5;
  localparam int STAT_BUSY  = 6;
  localparam int STAT_RST   = 8;
  localparam int TDATA_ST   = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [15:0] DESIG_RST = 16'h0000;
  localparam logic [15:0] LIFE_RST  = 16'hFFFF;

  // ****************************************
  // Tool data status codes
  // ****************************************
  localparam logic [2:0] ST_FREE   = 3'h0;
  localparam logic [2:0] ST_INUSE  = 3'h1;
  localparam logic [2:0] ST_OVER   = 3'h2;
  localparam logic [2:0] ST_ALARM1 = 3'h3;
  localparam logic [2:0] ST_ALARM2 = 3'h4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ  = 10;
  localparam int TICK_US  = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0]  st;
    logic [15:0] usage;
  } tls_tool_t;

endpackage : tls_pkg

// File: core/tls_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tls_sync #(
  parameter int W = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise
);
  import tls_pkg::*;

  typedef struct packed {
    logic [W-1:0] m1;
    logic [W-1:0] m2;
    logic [W-1:0] m3;
  } tls_sync_st_t;

  tls_sync_st_t q_r;
  tls_sync_st_t q_nxt;

  // Stage one feeds only stage two
  always_comb
  begin
    q_nxt    = q_r;
    q_nxt.m1 = pin;
    q_nxt.m2 = q_r.m1;
    q_nxt.m3 = q_r.m2;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign lvl  = q_r.m2;
  assign rise = q_r.m2 & ~q_r.m3;

endmodule : tls_sync
`default_nettype wire

// File: core/tls_axil.sv
`timescale 1ns/1ps
`default_nettype none
module tls_axil (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [tls_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [tls_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       wr_en,
  output logic [tls_pkg::AW-1:0]     wr_addr,
  output logic [31:0]                wr_data,
  output logic [3:0]                 wr_strb,
  input  wire logic                  wr_err,
  output logic                       rd_en,
  output logic [tls_pkg::AW-1:0]     rd_addr,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_err
);
  import tls_pkg::*;

  typedef struct packed {
    logic          aw_got;
    logic          w_got;
    logic [AW-1:0] awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } tls_axil_st_t;

  tls_axil_st_t q_r;
  tls_axil_st_t q_nxt;
  logic         aw_now;
  logic         w_now;

  assign s_axi_awready = !q_r.aw_got && !q_r.bvalid;
  assign s_axi_wready  = !q_r.w_got && !q_r.bvalid;
  assign s_axi_arready = !q_r.rvalid;
  assign aw_now        = s_axi_awvalid && s_axi_awready;
  assign w_now         = s_axi_wvalid && s_axi_wready;
  assign wr_en         = (q_r.aw_got || aw_now) && (q_r.w_got || w_now);
  assign wr_addr       = q_r.aw_got ? q_r.awaddr : s_axi_awaddr;
  assign wr_data       = q_r.w_got ? q_r.wdata : s_axi_wdata;
  assign wr_strb       = q_r.w_got ? q_r.wstrb : s_axi_wstrb;
  assign rd_en         = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = s_axi_araddr;

  always_comb
  begin
    q_nxt = q_r;
    if (q_r.bvalid && s_axi_bready)
      q_nxt.bvalid = 1'b0;
    if (q_r.rvalid && s_axi_rready)
      q_nxt.rvalid = 1'b0;
    if (aw_now)
    begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
    end
    if (w_now)
    begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_en)
    begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got  = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rd_en)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rdata  = rd_data;
      q_nxt.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp  = q_r.bresp;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata  = q_r.rdata;
  assign s_axi_rresp  = q_r.rresp;

endmodule : tls_axil
`default_nettype wire

// File: core/tls_core.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Alarm one command sets tool status three
// - Alarm one means skip tool on lathe
// - Milling honours alarm one, counter on enable
// - Alarm two sets status four under enable
// - Counter enable counts time or cycles
// - Management acts only while available, except group selection
// - Lathe change reset clears group usage
// - Designation picks exceeded groups or one
// - After reset, next selection takes head tool
// - Usage stays on tool current at reset
module tls_core #(
  parameter int unsigned TICK_CYCLES = tls_pkg::TICK_CYC
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   tool_alarm_first_cmd,
  input  wire logic                   tool_alarm_second_cmd,
  input  wire logic                   usage_counter_enable,
  input  wire logic                   life_mgmt_enable,
  input  wire logic                   tool_change_reset_cmd,
  input  wire logic                   cycle_done,
  input  wire logic [tls_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [tls_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [4:0]                  sel_tool_index,
  output logic                        sel_tool_valid
);
  import tls_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]             ctrl;
    logic [15:0]            desig;
    logic [15:0]            life;
    logic [4:0]             tidx;
    logic [2:0]             sel_grp;
    logic [1:0]             sel_tool;
    logic                   sel_valid;
    logic                   busy;
    logic [4:0]             walk;
    logic [NG-1:0]          target;
    logic [NG-1:0]          restart;
    logic [15:0]            tick;
    tls_tool_t [NT-1:0]     tools;
  } tls_core_st_t;
  tls_core_st_t q_r;
  tls_core_st_t q_nxt;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          wr_err;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_data;
  logic          rd_err;
  logic [5:0]    cmd_lvl;
  logic [5:0]    cmd_rise;
  logic          avail;
  logic          lathe;
  logic          gate;
  logic          a1_go;
  logic          a2_go;
  logic          trst_go;
  logic          cnt_ok;
  logic          tick_hit;
  logic          count_go;
  logic          sel_go;
  logic [4:0]    sel_idx;
  logic [31:0]   wmask;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
    hit = (a[AW-1:2] == ofs[7:2]);
  endfunction : hit
  function automatic logic reg_ok(input logic [AW-1:0] a, input logic wr);
    reg_ok = hit(a, OFS_CTRL) || hit(a, OFS_DESIG) || hit(a, OFS_LIFE)
          || hit(a, OFS_TIDX) || (wr ? hit(a, OFS_GSEL)
          : (hit(a, OFS_STAT) || hit(a, OFS_TDATA)));
  endfunction : reg_ok
  function automatic logic [NG-1:0] over_groups(input tls_tool_t [NT-1:0] t);
    logic [NG-1:0] m;
    m = '0;
    for (int i = 0; i < NT; i++)
      if (t[i].st == ST_OVER)
        m[i / TPG] = 1'b1;
    over_groups = m;
  endfunction : over_groups
  // Lowest tool of a group not in life-over or alarm state
  function automatic logic [2:0] first_usable(input tls_tool_t [NT-1:0] t,
                                              input logic [2:0] g);
    logic [2:0] r;
    r = 3'h0;
    for (int k = TPG - 1; k >= 0; k--)
      if (t[{g, 2'(k)}].st == ST_FREE || t[{g, 2'(k)}].st == ST_INUSE)
        r = {1'b1, 2'(k)};
    first_usable = r;
  endfunction : first_usable

  // ****************************************
  // Bus slave and input synchroniser
  // ****************************************
  tls_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  tls_sync #(
    .W (6)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     ({cycle_done, tool_change_reset_cmd, life_mgmt_enable,
               usage_counter_enable, tool_alarm_second_cmd,
               tool_alarm_first_cmd}),
    .lvl     (cmd_lvl),
    .rise    (cmd_rise)
  );

  // ****************************************
  // Command qualification
  // ****************************************
  assign avail   = q_r.ctrl[CTRL_AVAIL];
  assign lathe   = q_r.ctrl[CTRL_LATHE];
  assign sel_idx = {q_r.sel_grp, q_r.sel_tool};
  assign gate    = avail && (lathe || cmd_lvl[3]);
  assign a1_go   = cmd_rise[0] && gate && q_r.sel_valid;
  assign a2_go   = cmd_rise[1] && avail && cmd_lvl[3] && q_r.sel_valid;
  assign trst_go = cmd_rise[4] && avail && lathe && !q_r.busy;
  assign cnt_ok  = gate && cmd_lvl[2] && q_r.sel_valid;
  assign tick_hit = (q_r.tick == 16'(TICK_CYCLES - 1));
  assign count_go = cnt_ok && (q_r.ctrl[CTRL_CYC] ? cmd_rise[5] : tick_hit);
  assign sel_go  = wr_en && hit(wr_addr, OFS_GSEL) && wr_strb[0];
  assign wr_err  = !reg_ok(wr_addr, 1'b1);
  assign rd_err  = !reg_ok(rd_addr, 1'b0);

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_mask
      assign wmask[8*b +: 8] = {8{wr_strb[b]}};
    end
  endgenerate

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit(rd_addr, OFS_CTRL))
      rd_data[2:0] = q_r.ctrl;
    else if (hit(rd_addr, OFS_DESIG))
      rd_data[15:0] = q_r.desig;
    else if (hit(rd_addr, OFS_LIFE))
      rd_data[15:0] = q_r.life;
    else if (hit(rd_addr, OFS_TIDX))
      rd_data[4:0] = q_r.tidx;
    else if (hit(rd_addr, OFS_STAT))
    begin
      rd_data[2:0]                = q_r.sel_grp;
      rd_data[STAT_TOOL +: 2]     = q_r.sel_tool;
      rd_data[STAT_VALID]         = q_r.sel_valid;
      rd_data[STAT_BUSY]          = q_r.busy;
      rd_data[STAT_RST +: NG]     = q_r.restart;
    end
    else if (hit(rd_addr, OFS_TDATA))
    begin
      rd_data[15:0]           = q_r.tools[q_r.tidx].usage;
      rd_data[TDATA_ST +: 3]  = q_r.tools[q_r.tidx].st;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [2:0] fu;
    logic [2:0] g;
    logic [4:0] ti;
    fu    = 3'h0;
    g     = wr_data[2:0];
    ti    = 5'h00;
    q_nxt = q_r;
    q_nxt.tick = (tick_hit || !cnt_ok) ? 16'h0000 : q_r.tick + 16'h0001;
    if (count_go && q_r.tools[sel_idx].usage != 16'hFFFF)
    begin
      q_nxt.tools[sel_idx].usage = q_r.tools[sel_idx].usage + 16'h0001;
      if (q_r.tools[sel_idx].usage + 16'h0001 >= q_r.life
          && q_r.tools[sel_idx].st == ST_INUSE)
        q_nxt.tools[sel_idx].st = ST_OVER;
    end
    if (sel_go)
    begin
      fu = first_usable(q_r.tools, g);
      q_nxt.sel_grp = g;
      if (q_r.restart[g])
        fu = 3'b100;
      q_nxt.restart[g] = 1'b0;
      q_nxt.sel_tool   = fu[1:0];
      q_nxt.sel_valid  = fu[2];
      ti = {g, fu[1:0]};
      if (fu[2] && q_r.tools[ti].st == ST_FREE)
        q_nxt.tools[ti].st = ST_INUSE;
    end
    if (a1_go)
      q_nxt.tools[sel_idx].st = ST_ALARM1;
    if (a2_go)
      q_nxt.tools[sel_idx].st = ST_ALARM2;
    if (trst_go)
    begin
      q_nxt.busy = 1'b1;
      q_nxt.walk = 5'h00;
      if (q_r.desig == 16'h0000)
        q_nxt.target = over_groups(q_r.tools);
      else if (q_r.desig <= 16'(NG))
        q_nxt.target = NG'(1) << (q_r.desig - 16'h0001);
      else
        q_nxt.target = '0;
      q_nxt.restart = q_nxt.restart | q_nxt.target;
    end
    if (q_r.busy)
    begin
      if (q_r.target[q_r.walk[4:2]])
        q_nxt.tools[q_r.walk] = '0;
      q_nxt.walk = q_r.walk + 5'h01;
      if (q_r.walk == 5'(NT - 1))
        q_nxt.busy = 1'b0;
    end
    if (wr_en && hit(wr_addr, OFS_CTRL))
      q_nxt.ctrl = (q_r.ctrl & ~wmask[2:0]) | (wr_data[2:0] & wmask[2:0]);
    if (wr_en && hit(wr_addr, OFS_DESIG))
      q_nxt.desig = (q_r.desig & ~wmask[15:0]) | (wr_data[15:0] & wmask[15:0]);
    if (wr_en && hit(wr_addr, OFS_LIFE))
      q_nxt.life = (q_r.life & ~wmask[15:0]) | (wr_data[15:0] & wmask[15:0]);
    if (wr_en && hit(wr_addr, OFS_TIDX) && wr_strb[0])
      q_nxt.tidx = wr_data[4:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_r       <= '0;
      q_r.ctrl  <= CTRL_RST;
      q_r.desig <= DESIG_RST;
      q_r.life  <= LIFE_RST;
    end
    else
      q_r <= q_nxt;
  end

  assign sel_tool_index = sel_idx;
  assign sel_tool_valid = q_r.sel_valid;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_alarm1_status:
    assert property (a1_go && !a2_go && !q_r.busy
                     |=> q_r.tools[$past(sel_idx)].st == ST_ALARM1)
    else $error("alarm one did not set status three");
  chk_lathe_skip:
    assert property (cmd_rise[0] && avail && lathe && q_r.sel_valid |-> a1_go)
    else $error("lathe skip command ignored");
  chk_mill_gate:
    assert property (!lathe && !cmd_lvl[3] |-> !a1_go && !cnt_ok)
    else $error("milling command taken without enable");
  chk_alarm2_status:
    assert property (a2_go && !q_r.busy
                     |=> q_r.tools[$past(sel_idx)].st == ST_ALARM2)
    else $error("alarm two did not set status four");
  chk_count_hold:
    assert property (!cnt_ok && !q_r.busy |=> q_r.tools[$past(sel_idx)].usage
                     == $past(q_r.tools[sel_idx].usage))
    else $error("usage changed while counting disabled");
  chk_count_step:
    assert property (count_go && !q_r.busy && !sel_go
                     && q_r.tools[sel_idx].usage != 16'hFFFF
                     |=> q_r.tools[$past(sel_idx)].usage
                     == $past(q_r.tools[sel_idx].usage) + 16'h0001)
    else $error("usage not advanced by one");
  chk_mgmt_avail:
    assert property (!avail |-> !(a1_go || a2_go || trst_go || count_go))
    else $error("action while function unavailable");
  chk_reset_walk:
    assert property (trst_go |=> q_r.busy ##32 !q_r.busy)
    else $error("change reset walk length wrong");
  chk_one_group:
    assert property (trst_go && q_r.desig == 16'h0002
                     |=> q_r.target == 8'h02 && q_r.restart[1])
    else $error("designated group not targeted");
  chk_head_tool:
    assert property (sel_go && q_r.restart[wr_data[2:0]]
                     |=> q_r.sel_tool == 2'h0 && q_r.sel_valid)
    else $error("head tool not taken after reset");
  chk_tool_kept:
    assert property (q_r.busy && !sel_go |=> $stable(sel_idx))
    else $error("selected tool moved during reset");

endmodule : tls_core
`default_nettype wire

// File: verification/tls_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module tls_plc_model (
  input  wire logic       aclk,
  output logic      [5:0] pin
);
  // ****************************************
  // Command bits of the sequence program
  // ****************************************
  initial pin = 6'h00;

  // Bits change just after an edge and hold long enough to pass the input sync
  task automatic pulse(input int b);
    @(posedge aclk);
    pin[b] <= 1'b1;
    repeat (4) @(posedge aclk);
    pin[b] <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : pulse

  task automatic level(input int b, input logic v);
    @(posedge aclk);
    pin[b] <= v;
    repeat (4) @(posedge aclk);
  endtask : level
endmodule : tls_plc_model
`default_nettype wire

// File: verification/test_tool_life_status_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_tool_life_status_control;
  import tls_pkg::*;
  localparam int b_al1 = 0;
  localparam int b_al2 = 1;
  localparam int b_cen = 2;
  localparam int b_men = 3;
  localparam int b_trs = 4;
  localparam int b_cyc = 5;
  logic        aclk;
  logic        aresetn;
  logic [5:0]  pin;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [4:0]  sel_tool_index;
  logic        sel_tool_valid;
  int          miscompares;
  int          check_count;
  int          cyc;

  tls_plc_model u_plc (.aclk, .pin);

  tls_core #(.TICK_CYCLES(10)) u_dut (
    .aclk, .aresetn,
    .tool_alarm_first_cmd(pin[0]), .tool_alarm_second_cmd(pin[1]),
    .usage_counter_enable(pin[2]), .life_mgmt_enable(pin[3]),
    .tool_change_reset_cmd(pin[4]), .cycle_done(pin[5]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sel_tool_index, .sel_tool_valid
  );

  // ****************************************
  // Clock, timeout and closing report
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid  <= pw;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  task automatic tchk(input logic [4:0] i, input logic [2:0] st, input logic [15:0] u);
    wr(OFS_TIDX, {27'h0, i}, RESP_OKAY);
    rd(OFS_TDATA, {13'h0, st, u}, RESP_OKAY);
  endtask : tchk

  task automatic gsel(input logic [2:0] g, input logic [5:0] e);
    wr(OFS_GSEL, {29'h0, g}, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({26'h0, sel_tool_valid, sel_tool_index}, {26'h0, e});
  endtask : gsel

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    cyc = 0;
    miscompares = 0;
    check_count = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFS_LIFE, 32'h0000_FFFF, RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
    rd(OFS_GSEL, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_STAT, 32'h0000_00FF, RESP_SLVERR);
    wr(OFS_TDATA, 32'h0000_00FF, RESP_SLVERR);
    $display("register access test done");
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    gsel(3'h1, 6'h24);
    u_plc.pulse(b_al1);
    u_plc.pulse(b_al2);
    tchk(5'h04, ST_INUSE, 16'h0000);
    u_plc.level(b_men, 1'b1);
    u_plc.pulse(b_al1);
    tchk(5'h04, ST_ALARM1, 16'h0000);
    gsel(3'h2, 6'h28);
    u_plc.pulse(b_al2);
    tchk(5'h08, ST_ALARM2, 16'h0000);
    $display("alarm test done");
    wr(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    wr(OFS_LIFE, 32'h0000_0002, RESP_OKAY);
    gsel(3'h3, 6'h2C);
    u_plc.level(b_cen, 1'b1);
    u_plc.pulse(b_cyc);
    u_plc.pulse(b_cyc);
    u_plc.level(b_cen, 1'b0);
    u_plc.pulse(b_cyc);
    tchk(5'h0C, ST_OVER, 16'h0002);
    $display("usage count test done");
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    wr(OFS_DESIG, 32'h0000_0000, RESP_OKAY);
    gsel(3'h3, 6'h2D);
    u_plc.pulse(b_trs);
    repeat (40) @(posedge aclk);
    tchk(5'h0C, ST_FREE, 16'h0000);
    tchk(5'h04, ST_ALARM1, 16'h0000);
    tchk(5'h08, ST_ALARM2, 16'h0000);
    gsel(3'h3, 6'h2C);
    u_plc.level(b_men, 1'b0);
    u_plc.pulse(b_al1);
    tchk(5'h0C, ST_ALARM1, 16'h0000);
    $display("tool change reset test done");
    u_plc.level(b_cen, 1'b1);
    // 25 enabled cycles against a 10 cycle tick give two counts
    repeat (20) @(posedge aclk);
    u_plc.level(b_cen, 1'b0);
    tchk(5'h0C, ST_ALARM1, 16'h0002);
    wr(OFS_DESIG, 32'h0000_0002, RESP_OKAY);
    u_plc.pulse(b_trs);
    repeat (40) @(posedge aclk);
    tchk(5'h04, ST_FREE, 16'h0000);
    tchk(5'h08, ST_ALARM2, 16'h0000);
    rd(OFS_STAT, 32'h0000_0223, RESP_OKAY);
    $display("time count and single group test done");
    test_done();
  end
endmodule : test_tool_life_status_control
`default_nettype wire
